// *** hdl/cpg_pkg.sv ***
// Package for the clock pulse generator control block: register map, field layout,
// reset values, clock mode codes and the carrier types shared by the design files.
// Assumes a 32-bit APB slave with byte strobes and one system clock.
package cpg_pkg;

  localparam int unsigned CPG_ADDR_W      = 8;
  localparam logic [7:0]  CPG_FREQ_OFS    = 8'h00;
  localparam logic [7:0]  CPG_PHY_OFS     = 8'h04;
  localparam logic [7:0]  CPG_STATUS_OFS  = 8'h08;

  localparam int unsigned CPG_PFC_LSB     = 0;
  localparam int unsigned CPG_STC_LSB     = 4;
  localparam logic [15:0] CPG_FREQ_MASK   = 16'h0077;
  localparam logic [15:0] CPG_FREQ_RESET  = 16'h0003;
  localparam logic [7:0]  CPG_PHY_MASK    = 8'h03;
  localparam logic [7:0]  CPG_PHY_RESET   = 8'h00;
  localparam logic [7:0]  CPG_PHY_KEY     = 8'h5a;
  localparam logic [3:0]  CPG_WORD_STRB   = 4'h3;

  localparam logic [2:0]  CPG_STC_X1      = 3'h0;
  localparam logic [2:0]  CPG_STC_X2      = 3'h1;
  localparam logic [2:0]  CPG_PFC_DIV4    = 3'h0;
  localparam logic [2:0]  CPG_PFC_DIV2    = 3'h1;
  localparam logic [2:0]  CPG_PFC_DIV1    = 3'h3;
  localparam logic [1:0]  CPG_PHY_DIV1    = 2'h0;
  localparam logic [1:0]  CPG_PHY_DIV2    = 2'h1;
  localparam logic [1:0]  CPG_PHY_DIV4    = 2'h2;
  localparam logic [1:0]  CPG_PHY_DIV5    = 2'h3;

  localparam logic [2:0]  CPG_MODE_EXT_X4 = 3'h1;
  localparam logic [2:0]  CPG_MODE_XTL_X4 = 3'h2;
  localparam logic [2:0]  CPG_MODE_EXT_X2 = 3'h5;
  localparam logic [2:0]  CPG_MODE_XTL_X2 = 3'h6;
  localparam logic [2:0]  CPG_MODE_RESET  = 3'h1;
  localparam logic [1:0]  CPG_STRAP_WAIT  = 2'h3;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } cpg_apb_req_t;

  typedef struct packed {
    logic internal;
    logic periph;
    logic bus;
    logic phy;
  } cpg_clk_en_t;

  typedef enum logic [1:0] {
    CPG_RUN,
    CPG_PAUSE,
    CPG_STANDBY
  } cpg_state_t;

endpackage : cpg_pkg

// *** hdl/cpg_rate_div.sv ***
// Rate divider: emits one pulse for every ratio_i pulses of ce_i.
// Assumes ce_i is on the same clock; a ratio of zero behaves as one.
`timescale 1ns/1ps
module cpg_rate_div #(
  parameter int unsigned W = 3
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] ratio_i,
  output logic              pulse_o
);
  logic [W-1:0] count_reg;
  logic         last;

  assign last = (count_reg + W'(1) >= ratio_i);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      count_reg <= '0;
      pulse_o   <= 1'b0;
    end else if (ce_i) begin
      count_reg <= last ? '0 : count_reg + W'(1);
      pulse_o   <= last;
    end else begin
      pulse_o   <= 1'b0;
    end
  end
endmodule : cpg_rate_div

// *** hdl/cpg_ctrl.sv ***
// Clock pulse generator control: APB registers, clock mode strap, ratio change sequencing
// and the clock enable pulses for the internal, peripheral, bus and PHY domains.
// Assumes an outside watchdog that counts while wdt_count_en_o is high and reports overflow,
// and an outside standby controller that signals sleep entry and its mode change arm bit.
//
// Function
// - Mode pins are sampled only at power-on reset or armed standby entry.
// - Quadrupling modes multiply the external or crystal source by four.
// - Doubling modes multiply the external or crystal source by two.
// - Internal clock equals bus clock times the second-stage PLL ratio.
// - PHY clock is PLL output divided by 1, 2, 4 or 5.
// - Main divider offers only divide by 1, 2 and 4.
// - Bus clock always equals the bus clock output pin rate.
// - Frequency control is a 16-bit read/write word-access register.
// - Frequency control resets on external reset, survives watchdog reset.
// - PHY divider register takes word writes with key 0x5a upper byte.
// - Second-stage PLL ratio is one after reset.
// - Unarmed PLL ratio write pauses internal and peripheral clocks.
// - Watchdog overflow applies the new clocks, resumes and stops watchdog.
// - Peripheral divider only change applies at once, no pause.
// - Peripheral divider field resets to binary 011.
// - Armed writes take effect only after leaving software standby.
// - After a PLL ratio change, divider-only changes do not switch clocks.
// - Second-stage PLL passes or doubles its input per ratio field.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module cpg_ctrl
  import cpg_pkg::*;
(
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic         wdt_reset_i,
  input  wire logic         psel_i,
  input  wire logic         penable_i,
  input  wire cpg_apb_req_t apb_req_i,
  output logic              pready_o,
  output logic              pslverr_o,
  output logic [31:0]       prdata_o,
  input  wire logic [2:0]   clock_mode_select_pins_i,
  input  wire logic         mode_change_arm_i,
  input  wire logic         standby_entry_i,
  input  wire logic         wdt_overflow_i,
  output logic              wdt_count_en_o,
  output logic              wdt_stop_o,
  output logic              first_stage_x4_o,
  output logic              crystal_source_o,
  output logic              bus_clock_out_pin_o,
  output cpg_clk_en_t       clk_en_o
);

  cpg_state_t  state_reg;
  logic [2:0]  mode_meta_reg;
  logic [2:0]  mode_sync_reg;
  logic [2:0]  mode_reg;
  logic [1:0]  strap_cnt_reg;
  logic        mode_capture;
  logic        mode_valid;
  logic [15:0] freq_reg;
  logic [7:0]  phy_reg;
  logic [2:0]  pll_act_reg;
  logic [2:0]  pfc_act_reg;
  logic        stc_dirty_reg;
  logic        entry_armed_reg;
  logic        access;
  logic        freq_sel;
  logic        phy_sel;
  logic        stat_sel;
  logic        word_ok;
  logic        key_ok;
  logic        freq_wr;
  logic        phy_wr;
  logic [2:0]  new_stc;
  logic [2:0]  new_pfc;
  logic        stc_change;
  logic        wr_pause;
  logic        pfc_now;
  logic [2:0]  bus_ratio;
  logic [2:0]  per_ratio;
  logic [2:0]  phy_ratio;
  logic        bus_pulse;
  logic        per_pulse;
  logic        phy_pulse;
  logic [31:0] rd_value;

  // Mode pins come straight from the board, so they pass two flops first.
  always_ff @(posedge clk_sys_i) begin
    mode_meta_reg <= clock_mode_select_pins_i;
    mode_sync_reg <= mode_meta_reg;
  end

  // The strap is caught a few cycles after release, once the synchroniser holds pin levels.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      strap_cnt_reg <= CPG_STRAP_WAIT;
    end else if (strap_cnt_reg != 2'h0) begin
      strap_cnt_reg <= strap_cnt_reg - 2'h1;
    end
  end

  assign mode_valid   = (mode_sync_reg == CPG_MODE_EXT_X4) || (mode_sync_reg == CPG_MODE_XTL_X4) ||
                        (mode_sync_reg == CPG_MODE_EXT_X2) || (mode_sync_reg == CPG_MODE_XTL_X2);
  assign mode_capture = mode_valid && ((strap_cnt_reg == 2'h1) ||
                        (state_reg == CPG_RUN && standby_entry_i && mode_change_arm_i));

  // Unlisted pin codes are not legal modes; the last legal mode is kept instead.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mode_reg <= CPG_MODE_RESET;
    end else if (mode_capture) begin
      mode_reg <= mode_sync_reg;
    end
  end

  assign first_stage_x4_o = (mode_reg == CPG_MODE_EXT_X4) || (mode_reg == CPG_MODE_XTL_X4);
  assign crystal_source_o = (mode_reg == CPG_MODE_XTL_X4) || (mode_reg == CPG_MODE_XTL_X2);

  // APB decode. Both clock registers only accept 16-bit writes on the low half-word.
  assign access   = psel_i && penable_i;
  assign freq_sel = (apb_req_i.paddr == CPG_FREQ_OFS);
  assign phy_sel  = (apb_req_i.paddr == CPG_PHY_OFS);
  assign stat_sel = (apb_req_i.paddr == CPG_STATUS_OFS);
  assign word_ok  = (apb_req_i.pstrb == CPG_WORD_STRB);
  assign key_ok   = (apb_req_i.pwdata[15:8] == CPG_PHY_KEY);
  assign freq_wr  = access && apb_req_i.pwrite && freq_sel && word_ok;
  assign phy_wr   = access && apb_req_i.pwrite && phy_sel && word_ok && key_ok;
  assign pready_o = 1'b1;

  always_comb begin
    pslverr_o = 1'b0;
    if (access) begin
      if (!(freq_sel || phy_sel || stat_sel)) begin
        pslverr_o = 1'b1;
      end else if (apb_req_i.pwrite) begin
        pslverr_o = stat_sel || !word_ok || (phy_sel && !key_ok);
      end
    end
  end

  always_comb begin
    rd_value = 32'h0000_0000;
    if (freq_sel) begin
      rd_value[15:0] = freq_reg;
    end else if (phy_sel) begin
      rd_value[7:0] = phy_reg;
    end else if (stat_sel) begin
      rd_value[2:0]   = mode_reg;
      rd_value[6:4]   = pll_act_reg;
      rd_value[10:8]  = pfc_act_reg;
      rd_value[12]    = (state_reg == CPG_PAUSE);
      rd_value[13]    = (state_reg == CPG_STANDBY);
      rd_value[14]    = stc_dirty_reg;
    end
  end

  // Read data is latched in the setup phase so the bus sees a flop during the access phase.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      prdata_o <= rd_value;
    end
  end

  // Only the external reset clears the settings; a watchdog reset leaves them alone.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      freq_reg <= CPG_FREQ_RESET;
    end else if (freq_wr) begin
      freq_reg <= apb_req_i.pwdata[15:0] & CPG_FREQ_MASK;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      phy_reg <= CPG_PHY_RESET;
    end else if (phy_wr) begin
      phy_reg <= apb_req_i.pwdata[7:0] & CPG_PHY_MASK;
    end
  end

  assign new_stc    = apb_req_i.pwdata[CPG_STC_LSB +: 3];
  assign new_pfc    = apb_req_i.pwdata[CPG_PFC_LSB +: 3];
  assign stc_change = (new_stc != freq_reg[CPG_STC_LSB +: 3]);
  assign wr_pause   = freq_wr && !mode_change_arm_i && stc_change && state_reg == CPG_RUN;
  assign pfc_now    = freq_wr && !mode_change_arm_i && !stc_change && !stc_dirty_reg &&
                      state_reg == CPG_RUN;

  // Sequencing of ratio changes: pause on an unarmed PLL write, standby for mode changes.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || wdt_reset_i) begin
      state_reg       <= CPG_RUN;
      entry_armed_reg <= 1'b0;
    end else begin
      case (state_reg)
        CPG_RUN: begin
          if (wr_pause) begin
            state_reg <= CPG_PAUSE;
          end else if (standby_entry_i) begin
            state_reg       <= CPG_STANDBY;
            entry_armed_reg <= mode_change_arm_i;
          end
        end
        CPG_PAUSE: begin
          if (wdt_overflow_i) begin
            state_reg <= CPG_RUN;
          end
        end
        CPG_STANDBY: begin
          if (wdt_overflow_i) begin
            state_reg <= CPG_RUN;
          end
        end
        default: begin
          state_reg <= CPG_RUN;
        end
      endcase
    end
  end

  // The active ratios drive the bus and peripheral dividers; stored register values wait for the right moment.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pll_act_reg <= CPG_FREQ_RESET[CPG_STC_LSB +: 3];
      pfc_act_reg <= CPG_FREQ_RESET[CPG_PFC_LSB +: 3];
    end else if (wdt_reset_i) begin
      pll_act_reg <= freq_reg[CPG_STC_LSB +: 3];
      pfc_act_reg <= freq_reg[CPG_PFC_LSB +: 3];
    end else if ((state_reg == CPG_PAUSE && wdt_overflow_i) ||
                 (state_reg == CPG_STANDBY && wdt_overflow_i && entry_armed_reg)) begin
      pll_act_reg <= freq_reg[CPG_STC_LSB +: 3];
      pfc_act_reg <= freq_reg[CPG_PFC_LSB +: 3];
    end else if (pfc_now) begin
      pfc_act_reg <= new_pfc;
    end
  end

  // A pending PLL ratio blocks divider-only updates until a watchdog overflow ends a pause or standby.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || wdt_reset_i) begin
      stc_dirty_reg <= 1'b0;
    end else if (freq_wr && stc_change) begin
      stc_dirty_reg <= 1'b1;
    end else if (state_reg != CPG_RUN && wdt_overflow_i) begin
      stc_dirty_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wdt_stop_o <= 1'b0;
    end else begin
      wdt_stop_o <= (state_reg == CPG_PAUSE) && wdt_overflow_i;
    end
  end

  assign wdt_count_en_o = (state_reg != CPG_RUN);

  // Ratio decode. The system clock stands for the PLL output; every other rate is an enable.
  always_comb begin
    bus_ratio = (pll_act_reg == CPG_STC_X2) ? 3'h2 : 3'h1;
    case (pfc_act_reg)
      CPG_PFC_DIV2: per_ratio = 3'h2;
      CPG_PFC_DIV4: per_ratio = 3'h4;
      default:      per_ratio = 3'h1;
    endcase
    case (phy_reg[1:0])
      CPG_PHY_DIV2: phy_ratio = 3'h2;
      CPG_PHY_DIV4: phy_ratio = 3'h4;
      CPG_PHY_DIV5: phy_ratio = 3'h5;
      default:      phy_ratio = 3'h1;
    endcase
  end

  cpg_rate_div #(.W(3)) u_bus_div (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ce_i      (1'b1),
    .ratio_i   (bus_ratio),
    .pulse_o   (bus_pulse)
  );

  cpg_rate_div #(.W(3)) u_per_div (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ce_i      (1'b1),
    .ratio_i   (per_ratio),
    .pulse_o   (per_pulse)
  );

  cpg_rate_div #(.W(3)) u_phy_div (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ce_i      (1'b1),
    .ratio_i   (phy_ratio),
    .pulse_o   (phy_pulse)
  );

  // The bus clock and its pin come from one pulse, so they can never drift apart.
  assign bus_clock_out_pin_o = bus_pulse;
  assign clk_en_o.bus        = bus_pulse;
  assign clk_en_o.internal   = (state_reg == CPG_RUN);
  assign clk_en_o.periph     = per_pulse && (state_reg == CPG_RUN);
  assign clk_en_o.phy        = phy_pulse && (state_reg != CPG_STANDBY);

  property p_mode_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
      !$stable(mode_reg) |-> $past(mode_capture);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed without capture");

  property p_pause_on_stc;
    @(posedge clk_sys_i) disable iff (rst_i || wdt_reset_i)
      wr_pause |=> state_reg == CPG_PAUSE && !clk_en_o.internal && !clk_en_o.periph
                   && wdt_count_en_o;
  endproperty
  a_pause_on_stc: assert property (p_pause_on_stc) else $error("no pause on ratio write");

  property p_resume;
    @(posedge clk_sys_i) disable iff (rst_i || wdt_reset_i)
      (state_reg == CPG_PAUSE && wdt_overflow_i) |=>
        wdt_stop_o && clk_en_o.internal && pll_act_reg == $past(freq_reg[6:4]);
  endproperty
  a_resume: assert property (p_resume) else $error("no resume on overflow");

  property p_pfc_now;
    @(posedge clk_sys_i) disable iff (rst_i || wdt_reset_i)
      pfc_now |=> pfc_act_reg == $past(new_pfc) && state_reg == CPG_RUN;
  endproperty
  a_pfc_now: assert property (p_pfc_now) else $error("divider not applied at once");

  property p_arm_hold;
    @(posedge clk_sys_i) disable iff (rst_i || wdt_reset_i)
      (freq_wr && mode_change_arm_i && state_reg == CPG_RUN) |=>
        $stable(pll_act_reg) && $stable(pfc_act_reg);
  endproperty
  a_arm_hold: assert property (p_arm_hold) else $error("armed write changed clocks");

  property p_dirty_block;
    @(posedge clk_sys_i) disable iff (rst_i || wdt_reset_i)
      (stc_dirty_reg && freq_wr && !stc_change && state_reg == CPG_RUN) |=>
        $stable(pfc_act_reg);
  endproperty
  a_dirty_block: assert property (p_dirty_block) else $error("divider switched early");

  property p_bus_x2;
    @(posedge clk_sys_i) disable iff (rst_i)
      (bus_pulse && pll_act_reg == CPG_STC_X2 && $stable(pll_act_reg)) |=>
        !bus_pulse ##1 bus_pulse;
  endproperty
  a_bus_x2: assert property (p_bus_x2) else $error("bus rate wrong for doubled PLL");

  property p_phy_key;
    @(posedge clk_sys_i) disable iff (rst_i)
      (access && apb_req_i.pwrite && phy_sel && !key_ok) |=> $stable(phy_reg);
  endproperty
  a_phy_key: assert property (p_phy_key) else $error("keyless write changed phy divider");

  property p_wdt_keep;
    @(posedge clk_sys_i) disable iff (rst_i)
      (wdt_reset_i && !freq_wr) |=> $stable(freq_reg);
  endproperty
  a_wdt_keep: assert property (p_wdt_keep) else $error("watchdog reset changed settings");

  property p_reset_vals;
    @(posedge clk_sys_i) disable iff (rst_i)
      $fell(rst_i) |-> pll_act_reg == CPG_STC_X1 && freq_reg == CPG_FREQ_RESET;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("wrong reset ratios");

endmodule : cpg_ctrl

// *** sim/cpg_wdt_model.sv ***
// Watchdog stand-in for the clock generator: counts while allowed, pulses overflow once.
// Assumes the generator drops its count enable or pulses stop once it has resumed.
`timescale 1ns/1ps
module cpg_wdt_model #(
  parameter int unsigned LOAD = 60
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic count_en_i,
  input  wire logic stop_i,
  output logic      overflow_o
);
  logic [15:0] count_reg;
  logic        done_reg;

  // The count runs up from zero to LOAD-1 so that overflow comes well after the lock time.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !count_en_i || stop_i) begin
      count_reg  <= '0;
      done_reg   <= 1'b0;
      overflow_o <= 1'b0;
    end else if (!done_reg && count_reg == LOAD[15:0] - 16'h0001) begin
      done_reg   <= 1'b1;
      overflow_o <= 1'b1;
    end else begin
      overflow_o <= 1'b0;
      count_reg  <= done_reg ? count_reg : count_reg + 16'h0001;
    end
  end
endmodule : cpg_wdt_model

// *** sim/cpg_ctrl_tb.sv ***
// Self-checking bench for cpg_ctrl: registers over APB, ratio changes, strap and resets.
// Assumes the watchdog model supplies overflow pulses during pause and standby.
`timescale 1ns/1ps
module cpg_ctrl_tb;
  import cpg_pkg::*;
  logic         clk_sys_i   = 1'b0;
  logic         rst_i       = 1'b1;
  logic         wdt_reset_i = 1'b0;
  logic         psel        = 1'b0;
  logic         penable     = 1'b0;
  cpg_apb_req_t req         = '0;
  logic [2:0]   pins        = 3'h2;
  logic         arm         = 1'b0;
  logic         sby         = 1'b0;
  logic         pready;
  logic         pslverr;
  logic [31:0]  prdata;
  logic         ovf;
  logic         cnt_en;
  logic         wstop;
  logic         x4;
  logic         crystal_drive_pin;
  logic         bus_pin;
  cpg_clk_en_t  en;
  int           num_errors = 0;
  int           cmp_count  = 0;
  logic [31:0]  rd;
  logic         err;
  logic         saw;
  int           n_int, n_per, n_bus, n_phy;

  always #10 clk_sys_i = ~clk_sys_i;

  cpg_ctrl u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wdt_reset_i(wdt_reset_i),
    .psel_i(psel), .penable_i(penable), .apb_req_i(req), .pready_o(pready),
    .pslverr_o(pslverr), .prdata_o(prdata), .clock_mode_select_pins_i(pins),
    .mode_change_arm_i(arm), .standby_entry_i(sby), .wdt_overflow_i(ovf),
    .wdt_count_en_o(cnt_en), .wdt_stop_o(wstop), .first_stage_x4_o(x4),
    .crystal_source_o(crystal_drive_pin), .bus_clock_out_pin_o(bus_pin), .clk_en_o(en));

  cpg_wdt_model #(.LOAD(60)) u_wdt (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .count_en_i(cnt_en), .stop_i(wstop), .overflow_o(ovf));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Holds the request until pready is sampled high, then takes data and releases.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
    int t;
    @(posedge clk_sys_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    req     <= '{paddr: a, pwrite: w, pwdata: d, pstrb: s};
    @(posedge clk_sys_i);
    penable <= 1'b1;
    t = 0;
    @(posedge clk_sys_i);
    while (pready !== 1'b1 && t < 50) begin
      @(posedge clk_sys_i);
      t++;
    end
    if (t >= 50) num_errors++;
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic measure();
    n_int = 0;
    n_per = 0;
    n_bus = 0;
    n_phy = 0;
    // Eight cycles let every divider settle on its new ratio, so the window holds whole periods.
    repeat (8) @(negedge clk_sys_i);
    repeat (20) begin
      @(negedge clk_sys_i);
      if (en.internal === 1'b1) n_int++;
      if (en.periph === 1'b1) n_per++;
      if (en.bus === 1'b1) n_bus++;
      if (en.phy === 1'b1) n_phy++;
    end
  endtask : measure

  // Waits for the pause or standby to end; notes a stop pulse on the way.
  task automatic wait_run();
    int t;
    t   = 0;
    saw = 1'b0;
    do begin
      @(negedge clk_sys_i);
      if (wstop === 1'b1) saw = 1'b1;
      t++;
    end while (cnt_en !== 1'b0 && t < 300);
    if (t >= 300) num_errors++;
    repeat (10) @(negedge clk_sys_i);
  endtask : wait_run

  task automatic t_reset();
    apb(CPG_FREQ_OFS, 1'b0, 32'h0, 4'h0);
    chk("freq reset", rd, 32'h0000_0003);
    apb(CPG_PHY_OFS, 1'b0, 32'h0, 4'h0);
    chk("phy reset", rd, 32'h0);
    apb(CPG_STATUS_OFS, 1'b0, 32'h0, 4'h0);
    chk("mode", {29'h0, rd[2:0]}, 32'h2);
    chk("pll", {29'h0, rd[6:4]}, 32'h0);
    chk("x4 crystal", {30'h0, x4, crystal_drive_pin}, 32'h3);
    measure();
    chk("int rate", n_int, 20);
    chk("bus rate", n_bus, 20);
    chk("per rate", n_per, 20);
  endtask : t_reset

  task automatic t_phy();
    int div[4] = '{1, 2, 4, 5};
    for (int k = 0; k < 4; k++) begin
      apb(CPG_PHY_OFS, 1'b1, {16'h0, CPG_PHY_KEY, 6'h0, k[1:0]}, CPG_WORD_STRB);
      chk("phy err", {31'h0, err}, 32'h0);
      measure();
      chk("phy rate", n_phy, 20 / div[k]);
    end
    apb(CPG_PHY_OFS, 1'b1, 32'h0000_a500, CPG_WORD_STRB);
    chk("phy bad key", {31'h0, err}, 32'h1);
    apb(CPG_PHY_OFS, 1'b0, 32'h0, 4'h0);
    chk("phy kept", rd, 32'h3);
  endtask : t_phy

  task automatic t_access();
    apb(CPG_FREQ_OFS, 1'b1, 32'h0000_0001, 4'hf);
    chk("long write", {31'h0, err}, 32'h1);
    apb(CPG_FREQ_OFS, 1'b0, 32'h0, 4'h0);
    chk("freq kept", rd, 32'h3);
    apb(8'h0c, 1'b0, 32'h0, 4'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
  endtask : t_access

  // Runs on the doubled PLL: divide by four would put the peripheral clock below the bus
  // clock in every PLL setting, so software may never select it and it is not driven.
  task automatic t_pfc();
    logic [2:0] code[3] = '{CPG_PFC_DIV2, CPG_PFC_DIV1, CPG_PFC_DIV2};
    int         exp[3]  = '{10, 20, 10};
    for (int k = 0; k < 3; k++) begin
      apb(CPG_FREQ_OFS, 1'b1, {25'h0, CPG_STC_X2, 1'b0, code[k]}, CPG_WORD_STRB);
      @(negedge clk_sys_i);
      chk("no pause", {31'h0, cnt_en}, 32'h0);
      measure();
      chk("per rate", n_per, exp[k]);
      chk("int run", n_int, 20);
    end
  endtask : t_pfc

  task automatic t_pll();
    // The PHY is taken as held in reset and the watchdog preloaded here.
    apb(CPG_FREQ_OFS, 1'b1, 32'h0000_0013, CPG_WORD_STRB);
    repeat (2) @(negedge clk_sys_i);
    chk("wdt count", {31'h0, cnt_en}, 32'h1);
    measure();
    chk("pause int", n_int, 0);
    chk("pause per", n_per, 0);
    chk("pause bus", n_bus, 20);
    wait_run();
    chk("wdt stop", {31'h0, saw}, 32'h1);
    measure();
    chk("x2 int", n_int, 20);
    chk("x2 bus", n_bus, 10);
    chk("x2 per", n_per, 20);
    apb(CPG_STATUS_OFS, 1'b0, 32'h0, 4'h0);
    chk("pll x2", {29'h0, rd[6:4]}, 32'h1);
  endtask : t_pll

  task automatic t_mode();
    @(posedge clk_sys_i);
    pins <= 3'h5;
    repeat (6) @(negedge clk_sys_i);
    chk("pins ignored", {30'h0, x4, crystal_drive_pin}, 32'h3);
    @(posedge clk_sys_i);
    pins <= 3'h6;
    arm  <= 1'b1;
    // One armed write only; the register is left alone until the mode change is over.
    apb(CPG_FREQ_OFS, 1'b1, 32'h0000_0003, CPG_WORD_STRB);
    repeat (2) @(negedge clk_sys_i);
    chk("armed no pause", {31'h0, cnt_en}, 32'h0);
    apb(CPG_STATUS_OFS, 1'b0, 32'h0, 4'h0);
    chk("pfc held", {29'h0, rd[10:8]}, 32'h1);
    chk("pll held", {29'h0, rd[6:4]}, 32'h1);
    @(posedge clk_sys_i);
    sby  <= 1'b1;
    @(posedge clk_sys_i);
    sby  <= 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk("standby int", {31'h0, en.internal}, 32'h0);
    wait_run();
    @(posedge clk_sys_i);
    arm  <= 1'b0;
    chk("x2 crystal", {30'h0, x4, crystal_drive_pin}, 32'h1);
    measure();
    chk("new bus", n_bus, 20);
    chk("new per", n_per, 20);
  endtask : t_mode

  task automatic t_resets();
    // A value other than the reset one, so that a watchdog reset clearing it would show.
    apb(CPG_FREQ_OFS, 1'b1, 32'h0000_0013, CPG_WORD_STRB);
    wait_run();
    @(posedge clk_sys_i);
    wdt_reset_i <= 1'b1;
    @(posedge clk_sys_i);
    wdt_reset_i <= 1'b0;
    apb(CPG_FREQ_OFS, 1'b0, 32'h0, 4'h0);
    chk("freq kept", rd, 32'h13);
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    apb(CPG_FREQ_OFS, 1'b0, 32'h0, 4'h0);
    chk("freq init", rd, 32'h3);
  endtask : t_resets

  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    t_reset();
    t_phy();
    t_access();
    t_pll();
    t_pfc();
    t_mode();
    t_resets();
    test_done();
  end

  initial begin
    #(20 * 20000);
    num_errors++;
    test_done();
  end
endmodule : cpg_ctrl_tb
